// ### receive_wake_filter.sv
// Receive wake filter top: AXI4-Lite registers, event flags and wake output.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module receive_wake_filter
    import wake_filter_pkg::*;
#(
    parameter int ADDR_W = 14
)(
    input  wire logic              MCLK,          // 10 MHz clock.
    input  wire logic              RESET,         // Asynchronous reset, active high.
    input  wire logic              RX_SFD_ERROR,  // Frame start error pulse.
    input  wire logic              RX_BAD_CHECK,  // Bad frame check pulse.
    input  wire logic              RX_UNICAST,    // Unicast frame pulse.
    input  wire logic              RX_BROADCAST,  // Broadcast frame pulse.
    input  wire logic              RX_MATCH,      // Pattern match frame pulse.
    input  wire logic              RX_MAGIC,      // Magic frame pulse.
    output logic                   RX_FEATURE_EN, // Enhanced receive features on.
    output logic                   WAKE_OUT,      // Wake output to the GPIO pin.
    output logic                   IRQ,           // Interrupt, level.
    input  wire logic [ADDR_W-1:0] AWADDR,        // Write address.
    input  wire logic              AWVALID,       // Write address valid.
    output logic                   AWREADY,       // Write address ready.
    input  wire logic [31:0]       WDATA,         // Write data.
    input  wire logic [3:0]        WSTRB,         // Write strobes.
    input  wire logic              WVALID,        // Write data valid.
    output logic                   WREADY,        // Write data ready.
    output logic [1:0]             BRESP,         // Write response.
    output logic                   BVALID,        // Write response valid.
    input  wire logic              BREADY,        // Write response ready.
    input  wire logic [ADDR_W-1:0] ARADDR,        // Read address.
    input  wire logic              ARVALID,       // Read address valid.
    output logic                   ARREADY,       // Read address ready.
    output logic [31:0]            RDATA,         // Read data.
    output logic [1:0]             RRESP,         // Read response.
    output logic                   RVALID,        // Read data valid.
    input  wire logic              RREADY         // Read data ready.
);
    rx_events_t ev;
    logic [7:0] ev_bits;

    // Bus state.
    logic              aw_have_ff, nxt_aw_have;
    logic              w_have_ff, nxt_w_have;
    logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
    logic [31:0]       w_data_ff, nxt_w_data;
    logic [3:0]        w_strb_ff, nxt_w_strb;
    logic              bvalid_ff, nxt_bvalid;
    logic [1:0]        bresp_ff, nxt_bresp;
    logic              rvalid_ff, nxt_rvalid;
    logic [31:0]       rdata_ff, nxt_rdata;
    logic [1:0]        rresp_ff, nxt_rresp;

    // Register state.
    logic [15:0] cfg_ff, nxt_cfg;
    logic [7:0]  status_ff, nxt_status;
    logic [7:0]  mask_ff, nxt_mask;
    logic        irq_ff, nxt_irq;

    logic        do_write;
    logic        do_read;
    logic        status_read;
    logic        clear_pulse;
    logic        wake_trigger;
    logic [31:0] wr_merged;
    logic [31:0] mask_merged;

    assign ev = '{frame_start_error: RX_SFD_ERROR, bad_check: RX_BAD_CHECK,
                  unicast: RX_UNICAST, broadcast: RX_BROADCAST,
                  match: RX_MATCH, magic: RX_MAGIC};

    // Map events onto the status bit layout.
    always_comb begin
        ev_bits            = 8'h00;
        ev_bits[SFD_BIT]   = ev.frame_start_error;
        ev_bits[CRC_BIT]   = ev.bad_check;
        ev_bits[UCAST_BIT] = ev.unicast;
        ev_bits[BCAST_BIT] = ev.broadcast;
        ev_bits[MATCH_BIT] = ev.match;
        ev_bits[MAGIC_BIT] = ev.magic;
    end

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign AWREADY  = !aw_have_ff && !bvalid_ff;
    assign WREADY   = !w_have_ff && !bvalid_ff;
    assign ARREADY  = !rvalid_ff;
    assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;
    assign do_read  = ARVALID && ARREADY;
    assign status_read = do_read && (ARADDR[13:0] == STATUS_ADDR);
    assign wr_merged   = merge({16'h0000, cfg_ff}, w_data_ff, w_strb_ff);
    assign mask_merged = merge({24'h0, mask_ff}, w_data_ff, w_strb_ff);
    // The clear bit acts when its byte is written with a one.
    assign clear_pulse = do_write && (aw_addr_ff[13:0] == CFG_ADDR) && w_strb_ff[1]
                         && w_data_ff[CLEAR_BIT];

    // Only sources whose enable bit is set may wake.
    assign wake_trigger = |(ev_bits & cfg_ff[7:0] & WAKE_SOURCES);

    always_comb begin
        nxt_aw_have = aw_have_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_have  = w_have_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        nxt_cfg     = cfg_ff;
        nxt_mask    = mask_ff;
        // Events set flags regardless of enables; a set beats a read clear.
        nxt_status  = status_ff & ~(status_read ? STATUS_USED : 8'h00);
        nxt_status  = nxt_status | ev_bits;
        if (AWVALID && AWREADY) begin
            nxt_aw_have = 1'b1;
            nxt_aw_addr = AWADDR;
        end
        if (WVALID && WREADY) begin
            nxt_w_have = 1'b1;
            nxt_w_data = WDATA;
            nxt_w_strb = WSTRB;
        end
        if (do_write) begin
            nxt_aw_have = 1'b0;
            nxt_w_have  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = RESP_OKAY;
            unique case (aw_addr_ff[13:0])
                CFG_ADDR: nxt_cfg = wr_merged[15:0] & CFG_WRITE_MASK;
                MASK_ADDR: nxt_mask = mask_merged[7:0] & STATUS_USED;
                STATUS_ADDR: nxt_bresp = RESP_OKAY;
                default: nxt_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && BREADY) begin
            nxt_bvalid = 1'b0;
        end
        if (do_read) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            unique case (ARADDR[13:0])
                // The clear bit reads back the held level output.
                CFG_ADDR: nxt_rdata = {16'h0000, 4'h0, WAKE_OUT & cfg_ff[STYLE_BIT],
                                       cfg_ff[10:0]};
                STATUS_ADDR: nxt_rdata = {24'h0, status_ff};
                MASK_ADDR: nxt_rdata = {24'h0, mask_ff};
                default: begin
                    nxt_rdata = 32'h0;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && RREADY) begin
            nxt_rvalid = 1'b0;
        end
        nxt_irq = |(nxt_status & mask_ff);
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            aw_have_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_have_ff  <= 1'b0;
            w_data_ff  <= 32'h0;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= RESP_OKAY;
            cfg_ff     <= CFG_RESET;
            status_ff  <= STATUS_RESET;
            mask_ff    <= 8'h00;
            irq_ff     <= 1'b0;
        end else begin
            aw_have_ff <= nxt_aw_have;
            aw_addr_ff <= nxt_aw_addr;
            w_have_ff  <= nxt_w_have;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
            cfg_ff     <= nxt_cfg;
            status_ff  <= nxt_status;
            mask_ff    <= nxt_mask;
            irq_ff     <= nxt_irq;
        end
    end

    wake_pulse_gen u_wake (
        .clk        (MCLK),
        .rst        (RESET),
        .trigger    (wake_trigger),
        .level_mode (cfg_ff[STYLE_BIT] == STYLE_LEVEL),
        .width_code (cfg_ff[WIDTH_LSB +: 2]),
        .clear      (clear_pulse),
        .wake       (WAKE_OUT)
    );

    assign RX_FEATURE_EN = cfg_ff[FEATURE_BIT];
    assign IRQ    = irq_ff;
    assign BVALID = bvalid_ff;
    assign BRESP  = bresp_ff;
    assign RVALID = rvalid_ff;
    assign RDATA  = rdata_ff;
    assign RRESP  = rresp_ff;
endmodule

// ### receive_wake_filter_props.sv
// Concurrent checks on the ports of the receive wake filter.
`timescale 1ns/1ps
module receive_wake_filter_props (
    input wire logic        MCLK,         // Clock.
    input wire logic        RESET,        // Reset.
    input wire logic        RX_UNICAST,   // Event.
    input wire logic        RX_BROADCAST, // Event.
    input wire logic        RX_MATCH,     // Event.
    input wire logic        RX_MAGIC,     // Event.
    input wire logic        WAKE_OUT,     // Wake.
    input wire logic        IRQ,          // Interrupt.
    input wire logic        AWVALID,      // Bus.
    input wire logic        AWREADY,      // Bus.
    input wire logic        WVALID,       // Bus.
    input wire logic        WREADY,       // Bus.
    input wire logic        BVALID,       // Bus.
    input wire logic        BREADY,       // Bus.
    input wire logic        ARVALID,      // Bus.
    input wire logic        ARREADY,      // Bus.
    input wire logic        RVALID,       // Bus.
    input wire logic        RREADY,       // Bus.
    input wire logic [31:0] RDATA         // Bus.
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    a_wake_cause: assert property ($rose(WAKE_OUT) |-> $past(RX_UNICAST || RX_BROADCAST
        || RX_MATCH || RX_MAGIC)) else $error("wake rose without a frame event");
    // Interrupts only drop while a status read is answered or just after a mask write.
    a_irq_fall: assert property ($fell(IRQ) |-> RVALID || $past(RVALID)
        || $past(BVALID) || $past(BVALID, 2)) else $error("interrupt dropped unprompted");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read not answered next cycle");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
        else $error("write not answered in time");
    a_b_holds: assert property (BVALID && !BREADY |=> BVALID)
        else $error("write response withdrawn");
    a_r_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data changed while waiting");
    a_b_blocks_aw: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("new write accepted while response pending");
    a_r_blocks_ar: assert property (RVALID |-> !ARREADY)
        else $error("new read accepted while data pending");
endmodule

// ### receive_wake_filter_test.sv
// Self-checking bench for the receive wake filter.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module receive_wake_filter_test;
    import wake_filter_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [13:0] awaddr = 14'h0, araddr = 14'h0;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, resp, wresp;
    logic        awready, wready, bvalid, arready, rvalid, feat, wake, irq;
    logic [7:0]  len, rises, r0;
    rx_events_t  ev;
    int          err_total = 0, tests_run = 0, bits[4] = '{4, 2, 1, 0};
    always #50 mclk = ~mclk;
    rx_frame_source src (.clk(mclk), .rst(reset), .wake(wake), .ev(ev), .len(len), .rises(rises));
    receive_wake_filter uut (.MCLK(mclk), .RESET(reset), .RX_SFD_ERROR(ev.frame_start_error),
        .RX_BAD_CHECK(ev.bad_check), .RX_UNICAST(ev.unicast), .RX_BROADCAST(ev.broadcast),
        .RX_MATCH(ev.match), .RX_MAGIC(ev.magic), .RX_FEATURE_EN(feat), .WAKE_OUT(wake),
        .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            // Ready trails valid by a cycle so the slave must hold its answer.
            if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
            n++;
        end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 50);
        wresp = bresp;
        bready <= 1'b0;
        if (n >= 50) err_total++;
    endtask
    task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
            n++;
        end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 50) err_total++;
    endtask
    task automatic chk_rd(input logic [13:0] a, input logic [31:0] e);
        rd(a, rv, resp);
        `CHK(rv, e)
    endtask
    // Compares wait one nanosecond past the edge so registered outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #3000000;
        err_total++;
        complete_run;
    end
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        chk_rd(CFG_ADDR, 32'h0);
        chk_rd(STATUS_ADDR, 32'h0);
        chk_rd(MASK_ADDR, 32'h0);
        `CHK(feat, 1'b0)
        `CHK(wake, 1'b0)
        `CHK(irq, 1'b0)
        rd(14'h0, rv, resp);
        `CHK(resp, RESP_SLVERR)
        wr(14'h0, 32'hffff);
        `CHK(wresp, RESP_SLVERR)
        wr(STATUS_ADDR, 32'hff);
        `CHK(wresp, RESP_OKAY)
        chk_rd(STATUS_ADDR, 32'h0);
        $display("test reset and decode finished");
        wr(MASK_ADDR, 32'hd7);
        `CHK(wresp, RESP_OKAY)
        for (int c = 0; c < 4; c++) begin
            wr(CFG_ADDR, 32'h90 | (c << 9));
            `CHK(feat, 1'b1)
            src.send(6'h08);
            tick(80);
            `CHK(len, 8'(8 << c))
            chk_rd(STATUS_ADDR, 32'h10);
        end
        $display("test pulse widths finished");
        for (int i = 0; i < 4; i++) begin
            r0 = rises;
            wr(CFG_ADDR, 32'h80 | (32'h1 << bits[i]));
            src.send(6'h08 >> i);
            tick(2);
            `CHK(irq, 1'b1)
            `CHK(rises, r0 + 8'h1)
            chk_rd(STATUS_ADDR, 32'h1 << bits[i]);
            chk_rd(STATUS_ADDR, 32'h0);
            tick(2);
            `CHK(irq, 1'b0)
            wr(CFG_ADDR, 32'h80);
            src.send(6'h08 >> i);
            tick(80);
            `CHK(rises, r0 + 8'h1)
            chk_rd(STATUS_ADDR, 32'h1 << bits[i]);
        end
        $display("test wake sources finished");
        wr(MASK_ADDR, 32'h0);
        src.send(6'h30);
        tick(3);
        `CHK(irq, 1'b0)
        chk_rd(STATUS_ADDR, 32'hc0);
        chk_rd(STATUS_ADDR, 32'h0);
        $display("test error flags finished");
        wr(CFG_ADDR, 32'h190);
        src.send(6'h08);
        tick(100);
        `CHK(wake, 1'b1)
        chk_rd(CFG_ADDR, 32'h990);
        wr(CFG_ADDR, 32'h990);
        tick(2);
        `CHK(wake, 1'b0)
        chk_rd(CFG_ADDR, 32'h190);
        $display("test level mode finished");
        src.send(6'h08);
        tick(2);
        `CHK(wake, 1'b1)
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        #1;
        `CHK(wake, 1'b0)
        chk_rd(CFG_ADDR, 32'h0);
        chk_rd(STATUS_ADDR, 32'h0);
        $display("test mid-run reset finished");
        complete_run;
    end
endmodule
bind receive_wake_filter receive_wake_filter_props chk (.MCLK(MCLK), .RESET(RESET),
    .RX_UNICAST(RX_UNICAST), .RX_BROADCAST(RX_BROADCAST), .RX_MATCH(RX_MATCH),
    .RX_MAGIC(RX_MAGIC), .WAKE_OUT(WAKE_OUT), .IRQ(IRQ), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA));

// ### rx_frame_source.sv
// Receive-side frame event source and wake output monitor.
`timescale 1ns/1ps
module rx_frame_source
    import wake_filter_pkg::*;
(
    input  wire logic  clk,  // Clock.
    input  wire logic  rst,  // Reset.
    input  wire logic  wake, // Wake output under watch.
    output rx_events_t ev,   // One-cycle frame events.
    output logic [7:0] len,  // Length of the last wake pulse.
    output logic [7:0] rises // Count of wake rises.
);
    logic [7:0] run_ff;
    logic       wake_ff;
    initial ev = '0;
    // Events last one cycle, as the receive path delivers them.
    task automatic send(input logic [5:0] kind);
        @(posedge clk);
        ev <= kind;
        @(posedge clk);
        ev <= '0;
    endtask
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            run_ff <= 8'h0;
            wake_ff <= 1'b0;
            len <= 8'h0;
            rises <= 8'h0;
        end else begin
            wake_ff <= wake;
            if (wake) begin
                run_ff <= run_ff + 8'h1;
            end else if (run_ff != 8'h0) begin
                len <= run_ff;
                run_ff <= 8'h0;
            end
            if (wake && !wake_ff) begin
                rises <= rises + 8'h1;
            end
        end
    end
endmodule

// ### wake_filter_pkg.sv
// Package with register map, field layout and types of the receive wake filter.
package wake_filter_pkg;

    // Printed offsets are not all multiples of four, so they are word indices.
    localparam logic [11:0] CFG_INDEX    = 12'h134;
    localparam logic [11:0] STATUS_INDEX = 12'h135;
    localparam logic [11:0] MASK_INDEX   = 12'h136;
    localparam logic [13:0] CFG_ADDR     = {CFG_INDEX, 2'b00};
    localparam logic [13:0] STATUS_ADDR  = {STATUS_INDEX, 2'b00};
    localparam logic [13:0] MASK_ADDR    = {MASK_INDEX, 2'b00};

    localparam int CLEAR_BIT   = 11;
    localparam int WIDTH_LSB   = 9;
    localparam int STYLE_BIT   = 8;
    localparam int FEATURE_BIT = 7;
    localparam int UCAST_BIT   = 4;
    localparam int BCAST_BIT   = 2;
    localparam int MATCH_BIT   = 1;
    localparam int MAGIC_BIT   = 0;
    localparam int SFD_BIT     = 7;
    localparam int CRC_BIT     = 6;

    localparam logic [15:0] CFG_RESET      = 16'h0000;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h0797;
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    localparam logic [7:0]  STATUS_USED    = 8'hd7;
    localparam logic [7:0]  WAKE_SOURCES   = 8'h17;
    localparam logic [6:0]  PULSE_BASE     = 7'h08;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic {STYLE_PULSE, STYLE_LEVEL} wake_style_t;

    // One cycle frame events from the receive path.
    typedef struct packed {
        logic frame_start_error;
        logic bad_check;
        logic unicast;
        logic broadcast;
        logic match;
        logic magic;
    } rx_events_t;

    function automatic logic [6:0] pulse_cycles(input logic [1:0] code);
        pulse_cycles = PULSE_BASE << code;
    endfunction

endpackage

// ### wake_pulse_gen.sv
// Wake output generator: stretched pulse or held level.
`timescale 1ns/1ps
module wake_pulse_gen
    import wake_filter_pkg::*;
(
    input  wire logic       clk,        // System clock.
    input  wire logic       rst,        // Asynchronous reset, active high.
    input  wire logic       trigger,    // Enabled wake match, one cycle.
    input  wire logic       level_mode, // High selects held level.
    input  wire logic [1:0] width_code, // Pulse width code.
    input  wire logic       clear,      // Software clear of held level.
    output logic            wake        // Wake output, registered.
);
    logic [6:0] count_ff;
    logic [6:0] nxt_count;
    logic       wake_ff;
    logic       nxt_wake;

    always_comb begin
        nxt_count = count_ff;
        nxt_wake  = wake_ff;
        if (level_mode) begin
            nxt_count = 7'h00;
            // A new match in the clear cycle keeps the output up.
            if (trigger) begin
                nxt_wake = 1'b1;
            end else if (clear) begin
                nxt_wake = 1'b0;
            end
        end else if (trigger) begin
            // Retriggering restarts the full width.
            nxt_wake  = 1'b1;
            nxt_count = pulse_cycles(width_code) - 7'h01;
        end else if (count_ff != 7'h00) begin
            nxt_count = count_ff - 7'h01;
        end else begin
            nxt_wake = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_ff <= 7'h00;
            wake_ff  <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            wake_ff  <= nxt_wake;
        end
    end

    assign wake = wake_ff;
endmodule
